// *** pkg/dfa_defines.vh ***
// Constants for the 32-bit integer and single-precision arithmetic unit.
// Assumes word addressing on the Avalon-MM slave and 16-bit data words.
`ifndef DFA_DEFINES_VH
`define DFA_DEFINES_VH

// ----------------------------------------------------------------------
// Register map (word addresses); bit 10 set selects the data memory
// ----------------------------------------------------------------------
`define DFA_REG_CTRL     11'h000
`define DFA_REG_SRC1     11'h001
`define DFA_REG_SRC2     11'h002
`define DFA_REG_DST      11'h003
`define DFA_REG_STATUS   11'h004
`define DFA_MEM_SEL_BIT  10

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define DFA_CTRL_EN      0
`define DFA_CTRL_CNT     1
`define DFA_CTRL_OP_LO   4
`define DFA_CTRL_OP_HI   7

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define DFA_ST_BUSY      0
`define DFA_ST_ZERO      1
`define DFA_ST_CARRY     2
`define DFA_ST_BORROW    3
`define DFA_ST_DIVZ      4
`define DFA_ST_OPERR     5

// ----------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------
`define DFA_OP_ADD       4'h0
`define DFA_OP_SUB       4'h1
`define DFA_OP_DIV       4'h2
`define DFA_OP_SQRT      4'h3
`define DFA_OP_INC       4'h4
`define DFA_OP_DEC       4'h5
`define DFA_OP_ABS       4'h6
`define DFA_OP_NEG       4'h7
`define DFA_OP_WSUM      4'h8
`define DFA_OP_LSUM      4'h9
`define DFA_OP_FADD      4'ha
`define DFA_OP_FSUB      4'hb

// ----------------------------------------------------------------------
// Limits and counts
// ----------------------------------------------------------------------
`define DFA_CNT_LO       16'h00c8
`define DFA_CNT_HI       16'h00ff
`define DFA_CNT_BASE     16'h0300
`define DFA_SUM_MAX      16'h00ff
`define DFA_INT_MIN      32'h80000000
`define DFA_FLT_LIM_EXP  10'h0fe
`define DFA_DIV_ITER     9'h020
`define DFA_SQRT_ITER    9'h010

`endif

// *** src/dfa_float_addsub.v ***
// Single-precision add and subtract, purely combinational.
// Assumes normal operands; subnormals flush to zero, result truncates.
`timescale 1ns/1ps
`include "dfa_defines.vh"

module dfa_float_addsub (
  // Operands
  input  wire [31:0] opa,
  input  wire [31:0] opb,
  input  wire        sub,
  // Result
  output reg  [31:0] result,
  output reg         is_zero,
  output reg         overflow
);

  reg [7:0]  ea, eb, eh, el, d;
  reg        sa, sb, sh, sl;
  reg [26:0] ma, mb, mh, ml, ml_s;
  reg [27:0] sum, norm;
  reg [4:0]  lz;
  reg [9:0]  exp_r;
  integer    i;

  // ----------------------------------------------------------------------
  // Align, add, normalise
  // ----------------------------------------------------------------------
  always @* begin
    ea = opa[30:23];
    eb = opb[30:23];
    sa = opa[31];
    sb = opb[31] ^ sub;
    ma = (ea == 8'h00) ? 27'h0 : {1'b1, opa[22:0], 3'h0};
    mb = (eb == 8'h00) ? 27'h0 : {1'b1, opb[22:0], 3'h0};
    // Larger magnitude first keeps the difference non-negative
    if ({ea, ma} >= {eb, mb}) begin
      eh = ea; mh = ma; sh = sa; el = eb; ml = mb; sl = sb;
    end else begin
      eh = eb; mh = mb; sh = sb; el = ea; ml = ma; sl = sa;
    end
    d    = eh - el;
    ml_s = (d > 8'h1a) ? 27'h0 : (ml >> d);
    if (sh == sl)
      sum = {1'b0, mh} + {1'b0, ml_s};
    else
      sum = {1'b0, mh} - {1'b0, ml_s};
    lz = 5'h00;
    for (i = 0; i < 28; i = i + 1) begin
      if (sum[i])
        lz = 5'h1b - i[4:0];
    end
    norm     = sum << lz;
    exp_r    = {2'h0, eh} + 10'h001 - {5'h00, lz};
    overflow = 1'b0;
    is_zero  = 1'b0;
    if (sum == 28'h0 || exp_r[9] || exp_r == 10'h000) begin
      result  = 32'h0;
      is_zero = 1'b1;
    end else if (exp_r > 10'h0fe) begin
      result   = {sh, 8'hff, 23'h0};
      overflow = 1'b1;
    end else begin
      result   = {sh, exp_r[7:0], norm[26:4]};
      overflow = (exp_r == `DFA_FLT_LIM_EXP) && (norm[26:4] != 23'h0);
    end
  end

endmodule // dfa_float_addsub

// *** src/dfa_arith_unit.v ***
// Arithmetic unit: 32-bit integer ops and float add/subtract on a word memory.
// Assumes an Avalon-MM master with word addresses and a single clock domain.
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "dfa_defines.vh"

module dfa_arith_unit #(
  parameter MEM_AW = 10
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // Avalon-MM slave
  input  wire [10:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Status
  output wire        busy,
  output wire        zero_flag,
  output wire        carry_flag,
  output wire        borrow_flag,
  output wire        div_zero_err,
  output wire        operand_err
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_LOAD = 3'h1;
  localparam ST_DIV  = 3'h2;
  localparam ST_SQRT = 3'h3;
  localparam ST_SUM  = 3'h4;
  localparam ST_WR   = 3'h5;

  reg [15:0]       mem [0:(1<<MEM_AW)-1];
  reg [2:0]        state_ff,  nxt_state;
  reg [3:0]        op_ff,     nxt_op;
  reg              cnt_ff,    nxt_cnt;
  reg [15:0]       src1_ff,   nxt_src1;
  reg [15:0]       src2_ff,   nxt_src2;
  reg [15:0]       dst_ff,    nxt_dst;
  reg [31:0]       a_ff,      nxt_a;
  reg [31:0]       b_ff,      nxt_b;
  reg [32:0]       rem_ff,    nxt_rem;
  reg [31:0]       acc_ff,    nxt_acc;
  reg [63:0]       res_ff,    nxt_res;
  reg              sa_ff,     nxt_sa;
  reg              sb_ff,     nxt_sb;
  reg [8:0]        it_ff,     nxt_it;
  reg [MEM_AW-1:0] ptr_ff,    nxt_ptr;
  reg [MEM_AW-1:0] wbase_ff,  nxt_wbase;
  reg [2:0]        widx_ff,   nxt_widx;
  reg [2:0]        wlast_ff,  nxt_wlast;
  reg              zero_ff,   nxt_zero;
  reg              carry_ff,  nxt_carry;
  reg              borrow_ff, nxt_borrow;
  reg              divz_ff,   nxt_divz;
  reg              operr_ff,  nxt_operr;
  reg              wait_ff,   nxt_wait;
  reg              busy_ff;
  reg [31:0]       rdata_ff,  nxt_rdata;
  reg [31:0]       rd_mux;
  reg              set_divz, set_operr;
  reg [32:0]       sum33;
  reg [32:0]       trial;
  reg [31:0]       quo;

  // ----------------------------------------------------------------------
  // Operand fetch and helpers
  // ----------------------------------------------------------------------
  wire             req      = avs_read | avs_write;
  wire             idle     = (state_ff == ST_IDLE);
  wire             is_stat  = (avs_address == `DFA_REG_STATUS);
  // Only status stays reachable mid-operation, so operands cannot shift under it
  wire             blocked  = ~idle & ~is_stat;
  wire             take     = req & ~wait_ff;
  wire             in_mem   = avs_address[`DFA_MEM_SEL_BIT];
  wire [MEM_AW-1:0] av_idx  = avs_address[MEM_AW-1:0];
  wire             self_op  = (op_ff == `DFA_OP_INC) || (op_ff == `DFA_OP_DEC);
  wire [15:0]      cnt_off  = (dst_ff - `DFA_CNT_LO) << 1;
  wire [15:0]      cnt_addr = `DFA_CNT_BASE + cnt_off;
  wire [MEM_AW-1:0] dst_addr = cnt_ff ? cnt_addr[MEM_AW-1:0] : dst_ff[MEM_AW-1:0];
  wire [MEM_AW-1:0] p1      = self_op ? dst_addr : src1_ff[MEM_AW-1:0];
  wire [MEM_AW-1:0] p2      = src2_ff[MEM_AW-1:0];
  wire [MEM_AW-1:0] p1_n    = p1 + 1'b1;
  wire [MEM_AW-1:0] p2_n    = p2 + 1'b1;
  wire [MEM_AW-1:0] ptr_n   = ptr_ff + 1'b1;
  wire [31:0]      opa      = {mem[p1_n], mem[p1]};
  wire [31:0]      opb      = {mem[p2_n], mem[p2]};
  wire [31:0]      sum_wd   = {{16{mem[ptr_ff][15]}}, mem[ptr_ff]};
  wire [31:0]      sum_ld   = {mem[ptr_n], mem[ptr_ff]};
  wire             cnt_bad  = cnt_ff && ((dst_ff < `DFA_CNT_LO) || (dst_ff > `DFA_CNT_HI));
  wire             clr_w    = take & avs_write & is_stat;
  wire [31:0]      f_res;
  wire             f_zero;
  wire             f_ovf;

  dfa_float_addsub u_float (
    .opa      (opa),
    .opb      (opb),
    .sub      (op_ff == `DFA_OP_FSUB),
    .result   (f_res),
    .is_zero  (f_zero),
    .overflow (f_ovf)
  );

  // ----------------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------------
  always @* begin
    rd_mux = 32'h0;
    if (in_mem)
      rd_mux = {16'h0, mem[av_idx]};
    else begin
      case (avs_address)
        `DFA_REG_CTRL:   rd_mux = {24'h0, op_ff, 2'h0, cnt_ff, 1'b0};
        `DFA_REG_SRC1:   rd_mux = {16'h0, src1_ff};
        `DFA_REG_SRC2:   rd_mux = {16'h0, src2_ff};
        `DFA_REG_DST:    rd_mux = {16'h0, dst_ff};
        `DFA_REG_STATUS: rd_mux = {26'h0, operr_ff, divz_ff, borrow_ff, carry_ff,
                                   zero_ff, ~idle};
        default:         rd_mux = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;  nxt_op    = op_ff;    nxt_cnt   = cnt_ff;
    nxt_src1  = src1_ff;   nxt_src2  = src2_ff;  nxt_dst   = dst_ff;
    nxt_a     = a_ff;      nxt_b     = b_ff;     nxt_rem   = rem_ff;
    nxt_acc   = acc_ff;    nxt_res   = res_ff;   nxt_sa    = sa_ff;
    nxt_sb    = sb_ff;     nxt_it    = it_ff;    nxt_ptr   = ptr_ff;
    nxt_wbase = wbase_ff;  nxt_widx  = widx_ff;  nxt_wlast = wlast_ff;
    nxt_zero  = zero_ff;   nxt_carry = carry_ff; nxt_borrow = borrow_ff;
    nxt_rdata = rdata_ff;
    set_divz  = 1'b0;
    set_operr = 1'b0;
    sum33     = 33'h0;
    trial     = 33'h0;
    quo       = 32'h0;
    nxt_wait  = ~(req & wait_ff & ~blocked);
    if (req & wait_ff & ~blocked & avs_read)
      nxt_rdata = rd_mux;
    if (take & avs_write & ~in_mem) begin
      case (avs_address)
        `DFA_REG_SRC1: nxt_src1 = avs_writedata[15:0];
        `DFA_REG_SRC2: nxt_src2 = avs_writedata[15:0];
        `DFA_REG_DST:  nxt_dst  = avs_writedata[15:0];
        `DFA_REG_CTRL: begin
          nxt_op  = avs_writedata[`DFA_CTRL_OP_HI:`DFA_CTRL_OP_LO];
          nxt_cnt = avs_writedata[`DFA_CTRL_CNT];
          if (avs_writedata[`DFA_CTRL_EN])
            nxt_state = ST_LOAD;
        end
        default: nxt_state = state_ff;
      endcase
    end
    case (state_ff)
      ST_IDLE: nxt_widx = 3'h0;
      ST_LOAD: begin
        nxt_state = ST_WR;
        nxt_wbase = dst_addr;
        nxt_wlast = 3'h1;
        if (cnt_bad) begin
          set_operr = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          case (op_ff)
            `DFA_OP_ADD, `DFA_OP_SUB: begin
              if (op_ff == `DFA_OP_ADD)
                sum33 = {opa[31], opa} + {opb[31], opb};
              else
                sum33 = {opa[31], opa} - {opb[31], opb};
              nxt_res    = {32'h0, sum33[31:0]};
              nxt_carry  = (sum33[32:31] == 2'b01);
              nxt_borrow = (sum33[32:31] == 2'b10);
              nxt_zero   = (sum33[31:0] == 32'h0);
            end
            `DFA_OP_DIV: begin
              if (opb == 32'h0) begin
                set_divz  = 1'b1;
                nxt_state = ST_IDLE;
              end else begin
                nxt_sa    = opa[31];
                nxt_sb    = opb[31];
                nxt_a     = opa[31] ? (32'h0 - opa) : opa;
                nxt_b     = opb[31] ? (32'h0 - opb) : opb;
                nxt_rem   = 33'h0;
                nxt_it    = `DFA_DIV_ITER;
                nxt_state = ST_DIV;
              end
            end
            `DFA_OP_SQRT: begin
              if (opa[31]) begin
                set_operr = 1'b1;
                nxt_state = ST_IDLE;
              end else begin
                nxt_a     = opa;
                nxt_acc   = 32'h0;
                nxt_rem   = 33'h0;
                nxt_it    = `DFA_SQRT_ITER;
                nxt_state = ST_SQRT;
              end
            end
            `DFA_OP_INC: nxt_res = {32'h0, opa + 32'h1};
            `DFA_OP_DEC: nxt_res = {32'h0, opa - 32'h1};
            `DFA_OP_ABS, `DFA_OP_NEG: begin
              if (opa == `DFA_INT_MIN) begin
                set_operr = 1'b1;
                nxt_state = ST_IDLE;
              end else begin
                if (op_ff == `DFA_OP_NEG || opa[31])
                  nxt_res = {32'h0, 32'h0 - opa};
                else
                  nxt_res = {32'h0, opa};
                nxt_zero   = (opa == 32'h0);
                nxt_carry  = 1'b0;
                nxt_borrow = 1'b0;
              end
            end
            `DFA_OP_WSUM, `DFA_OP_LSUM: begin
              if (src2_ff > `DFA_SUM_MAX) begin
                set_operr = 1'b1;
                nxt_state = ST_IDLE;
              end else begin
                nxt_acc   = 32'h0;
                nxt_ptr   = src1_ff[MEM_AW-1:0];
                nxt_it    = src2_ff[8:0];
                nxt_state = ST_SUM;
              end
            end
            `DFA_OP_FADD, `DFA_OP_FSUB: begin
              nxt_res    = {32'h0, f_res};
              nxt_carry  = f_ovf;
              nxt_zero   = f_zero;
              nxt_borrow = 1'b0;
            end
            default: nxt_state = ST_IDLE;
          endcase
        end
      end
      ST_DIV: begin
        if (it_ff == 9'h000) begin
          // Quotient takes the XOR of the operand signs, remainder the dividend's sign
          quo       = (sa_ff ^ sb_ff) ? (32'h0 - a_ff) : a_ff;
          nxt_res   = {(sa_ff ? (32'h0 - rem_ff[31:0]) : rem_ff[31:0]), quo};
          nxt_wlast = 3'h3;
          nxt_state = ST_WR;
        end else begin
          trial  = {rem_ff[31:0], a_ff[31]} - {1'b0, b_ff};
          nxt_it = it_ff - 9'h001;
          if (!trial[32]) begin
            nxt_rem = trial;
            nxt_a   = {a_ff[30:0], 1'b1};
          end else begin
            nxt_rem = {rem_ff[31:0], a_ff[31]};
            nxt_a   = {a_ff[30:0], 1'b0};
          end
        end
      end
      ST_SQRT: begin
        if (it_ff == 9'h000) begin
          nxt_res    = {32'h0, acc_ff};
          nxt_zero   = (acc_ff == 32'h0);
          nxt_borrow = (rem_ff != 33'h0);
          nxt_carry  = 1'b0;
          nxt_wlast  = 3'h1;
          nxt_state  = ST_WR;
        end else begin
          nxt_it  = it_ff - 9'h001;
          nxt_a   = {a_ff[29:0], 2'h0};
          nxt_rem = {rem_ff[30:0], a_ff[31:30]};
          trial   = {rem_ff[30:0], a_ff[31:30]} - {acc_ff[30:0], 2'h1};
          if (!trial[32]) begin
            nxt_rem = trial;
            nxt_acc = {acc_ff[30:0], 1'b1};
          end else
            nxt_acc = {acc_ff[30:0], 1'b0};
        end
      end
      ST_SUM: begin
        if (it_ff == 9'h000) begin
          nxt_res    = {32'h0, acc_ff};
          nxt_zero   = (acc_ff == 32'h0);
          nxt_carry  = 1'b0;
          nxt_borrow = 1'b0;
          nxt_wlast  = 3'h1;
          nxt_state  = ST_WR;
        end else begin
          nxt_it = it_ff - 9'h001;
          if (op_ff == `DFA_OP_WSUM) begin
            nxt_acc = acc_ff + sum_wd;
            nxt_ptr = ptr_n;
          end else begin
            nxt_acc = acc_ff + sum_ld;
            nxt_ptr = ptr_n + 1'b1;
          end
        end
      end
      ST_WR: begin
        nxt_widx = widx_ff + 3'h1;
        if (widx_ff == wlast_ff)
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
    // Sticky errors, write one to clear; a new error wins over the clear
    nxt_divz  = (divz_ff & ~(clr_w & avs_writedata[`DFA_ST_DIVZ])) | set_divz;
    nxt_operr = (operr_ff & ~(clr_w & avs_writedata[`DFA_ST_OPERR])) | set_operr;
  end

  // ----------------------------------------------------------------------
  // Data memory: bus writes only while idle, result writes only in ST_WR
  // ----------------------------------------------------------------------
  wire [MEM_AW-1:0] wr_addr = wbase_ff + {{(MEM_AW-3){1'b0}}, widx_ff};

  always @(posedge sys_clk) begin
    if (state_ff == ST_WR)
      mem[wr_addr] <= res_ff[widx_ff*16 +: 16];
    else if (take & avs_write & in_mem)
      mem[av_idx] <= avs_writedata[15:0];
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff  <= ST_IDLE;  op_ff     <= 4'h0;    cnt_ff    <= 1'b0;
      src1_ff   <= 16'h0;    src2_ff   <= 16'h0;   dst_ff    <= 16'h0;
      a_ff      <= 32'h0;    b_ff      <= 32'h0;   rem_ff    <= 33'h0;
      acc_ff    <= 32'h0;    res_ff    <= 64'h0;   sa_ff     <= 1'b0;
      sb_ff     <= 1'b0;     it_ff     <= 9'h000;
      ptr_ff    <= {MEM_AW{1'b0}};
      wbase_ff  <= {MEM_AW{1'b0}};
      widx_ff   <= 3'h0;     wlast_ff  <= 3'h0;
      zero_ff   <= 1'b0;     carry_ff  <= 1'b0;    borrow_ff <= 1'b0;
      divz_ff   <= 1'b0;     operr_ff  <= 1'b0;
      wait_ff   <= 1'b1;     rdata_ff  <= 32'h0;     busy_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;  op_ff     <= nxt_op;    cnt_ff    <= nxt_cnt;
      src1_ff   <= nxt_src1;   src2_ff   <= nxt_src2;  dst_ff    <= nxt_dst;
      a_ff      <= nxt_a;      b_ff      <= nxt_b;     rem_ff    <= nxt_rem;
      acc_ff    <= nxt_acc;    res_ff    <= nxt_res;   sa_ff     <= nxt_sa;
      sb_ff     <= nxt_sb;     it_ff     <= nxt_it;    ptr_ff    <= nxt_ptr;
      wbase_ff  <= nxt_wbase;  widx_ff   <= nxt_widx;  wlast_ff  <= nxt_wlast;
      zero_ff   <= nxt_zero;   carry_ff  <= nxt_carry; borrow_ff <= nxt_borrow;
      divz_ff   <= nxt_divz;   operr_ff  <= nxt_operr;
      wait_ff   <= nxt_wait;   rdata_ff  <= nxt_rdata;  busy_ff   <= (nxt_state != ST_IDLE);
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign busy            = busy_ff;
  assign zero_flag       = zero_ff;
  assign carry_flag      = carry_ff;
  assign borrow_flag     = borrow_ff;
  assign div_zero_err    = divz_ff;
  assign operand_err     = operr_ff;

endmodule // dfa_arith_unit

// *** tb/dfa_arith_unit_sva.sv ***
// Checker for the unit's bus handshake and status ports.
// Assumes one clock domain and the register map of dfa_defines.vh.
`timescale 1ns/1ps
`include "dfa_defines.vh"
module dfa_arith_unit_sva (
  // Clock and reset
  input wire        sys_clk,
  input wire        reset_n,
  // Bus
  input wire [10:0] avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // Status
  input wire        busy,
  input wire        zero_flag,
  input wire        carry_flag,
  input wire        borrow_flag,
  input wire        div_zero_err,
  input wire        operand_err
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire st_a = avs_address == `DFA_REG_STATUS;
  wire tk_w = avs_write && !avs_waitrequest;
  wire go   = tk_w && avs_address == `DFA_REG_CTRL && avs_writedata[0];
  wire clr  = tk_w && st_a && avs_writedata[5];
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_go; go; endsequence
  property p_ans; s_req ##0 (!busy || st_a) |=> !avs_waitrequest; endproperty
  property p_stall; s_req ##0 (busy && !st_a) |=> avs_waitrequest; endproperty
  property p_pulse; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
  property p_go; s_go |=> busy; endproperty
  property p_end; s_go ##1 busy |-> ##[1:300] !busy; endproperty
  property p_hold; !busy && !go |=> $stable({zero_flag, carry_flag, borrow_flag}); endproperty
  property p_sticky; operand_err && !clr |=> operand_err; endproperty
  property p_cause; $rose(operand_err) || $rose(div_zero_err) |-> $past(busy); endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  a_stall: assert property (p_stall) else $error("not stalled");
  a_pulse: assert property (p_pulse) else $error("long answer");
  a_go: assert property (p_go) else $error("no start");
  a_end: assert property (p_end) else $error("hung");
  a_hold: assert property (p_hold) else $error("flags moved");
  a_sticky: assert property (p_sticky) else $error("error lost");
  a_cause: assert property (p_cause) else $error("error idle");
endmodule // dfa_arith_unit_sva

bind dfa_arith_unit dfa_arith_unit_sva u_sva (
  .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .busy(busy), .zero_flag(zero_flag),
  .carry_flag(carry_flag), .borrow_flag(borrow_flag), .div_zero_err(div_zero_err),
  .operand_err(operand_err));

// *** tb/dfa_seq_model.sv ***
// Sequencer model: single Avalon-MM accesses to the unit.
// Assumes an answer within 400 clocks, else timed_out rises.
`timescale 1ns/1ps
module dfa_seq_model (
  // Clock
  input  wire         sys_clk,
  // Avalon-MM master
  output logic [10:0] avs_address,
  output logic        avs_read,
  output logic        avs_write,
  output logic [31:0] avs_writedata,
  input  wire  [31:0] avs_readdata,
  input  wire         avs_waitrequest,
  // Hang report
  output logic        timed_out
);
  initial begin
    avs_address = 11'h7ff;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    timed_out = 1'b0;
  end
  task automatic xfer(input logic w, input logic [10:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= d;
    n = 0;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    q = avs_readdata;
    if (n >= 400) timed_out <= 1'b1;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d; // No stale data once released
    avs_address <= ~a;
    @(posedge sys_clk);
  endtask
endmodule // dfa_seq_model

// *** tb/tb.sv ***
// Bench: one task per behaviour, each judging its own results.
// Assumes operands at words 0x10 and 0x12, result at 0x30.
`timescale 1ns/1ps
`include "dfa_defines.vh"
module tb;
  localparam logic [31:0] K = 32'h5a5a5a5a;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  int         errors = 0;
  int         num_checks = 0;
  wire [10:0] adr;
  wire [31:0] wd, rd;
  wire        rq, wq, wr, bz, zf, cf, bf, dz, oe, to;
  dfa_arith_unit DUT (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rq),
    .avs_write(wq), .avs_writedata(wd), .avs_readdata(rd), .avs_waitrequest(wr), .busy(bz),
    .zero_flag(zf), .carry_flag(cf), .borrow_flag(bf), .div_zero_err(dz), .operand_err(oe));
  dfa_seq_model u_seq (.sys_clk(sys_clk), .avs_address(adr), .avs_read(rq), .avs_write(wq),
    .avs_writedata(wd), .avs_readdata(rd), .avs_waitrequest(wr), .timed_out(to));
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic hang;
    errors++;
    tally_and_finish;
  endtask
  always @(posedge to) hang;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic w(input logic [10:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_seq.xfer(1'b1, a, d, q);
  endtask
  task automatic r(input logic [10:0] a, output logic [31:0] q);
    u_seq.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic wm(input logic [9:0] a, input logic [31:0] v);
    w({1'b1, a}, {16'h0, v[15:0]});
    w({1'b1, a + 10'h1}, {16'h0, v[31:16]});
  endtask
  task automatic rm(input logic [9:0] a, output logic [31:0] v);
    logic [31:0] lo, hi;
    r({1'b1, a}, lo);
    r({1'b1, a + 10'h1}, hi);
    v = {hi[15:0], lo[15:0]};
  endtask
  task automatic sts(input logic [5:0] e, input logic [5:0] m);
    logic [31:0] q;
    r(`DFA_REG_STATUS, q);
    chk("status", {26'h0, e & m}, q & {26'h0, m});
    chk("flags", {26'h0, e & m}, {26'h0, {oe, dz, bf, cf, zf, bz} & m});
  endtask
  task automatic run(input logic [7:0] c, input logic [15:0] s2, input logic [15:0] d);
    logic [31:0] q;
    int n;
    w(`DFA_REG_STATUS, 32'h30);
    w(`DFA_REG_SRC1, 32'h10);
    w(`DFA_REG_SRC2, {16'h0, s2});
    w(`DFA_REG_DST, {16'h0, d});
    w(`DFA_REG_CTRL, {24'h0, c});
    chk("busy", {31'h0, c[0]}, {31'h0, bz});
    r(`DFA_REG_SRC1, q); // Stalled until idle
    chk("src1", 32'h10, q);
    for (n = 0; n < 400 && q[0] !== 1'b0; n++) r(`DFA_REG_STATUS, q);
    if (q[0] !== 1'b0) hang;
  endtask
  task automatic t(input logic [7:0] c, input logic [31:0] a, b, input logic [15:0] s2,
                   input logic [31:0] e, input logic [5:0] st);
    logic [31:0] v;
    logic [5:0]  m;
    m = st[5] ? 6'h20 : (c[7:4] inside {4'h2, 4'h4, 4'h5}) ? 6'h30 : 6'h3f;
    wm(10'h10, a);
    wm(10'h12, b);
    wm(10'h30, (c[7:5] == 3'h2) ? a : K);
    run(c, s2, 16'h30);
    rm(10'h30, v);
    chk("dest", e, v);
    sts(st, m);
  endtask
  task automatic t_int;
    logic [31:0] v;
    t(8'h01, 32'h7fffffff, 32'h1, 16'h12, 32'h80000000, 6'h04);
    t(8'h11, 32'h80000000, 32'h1, 16'h12, 32'h7fffffff, 6'h08);
    t(8'h01, 32'h5, 32'hfffffffb, 16'h12, 32'h0, 6'h02);
    r(11'h005, v);
    chk("unmapped", 32'h0, v);
  endtask
  task automatic t_div;
    logic [31:0] v;
    t(8'h21, 32'hfffebbc8, 32'h7d0, 16'h12, 32'hffffffd7, 6'h00);
    rm(10'h32, v);
    chk("remainder", 32'hfffffc18, v);
    t(8'h21, 32'h5, 32'h0, 16'h12, K, 6'h10);
  endtask
  task automatic t_sqrt;
    t(8'h31, 32'h14438, 32'h0, 16'h12, 32'h120, 6'h08);
    t(8'h31, 32'h0, 32'h0, 16'h12, 32'h0, 6'h02);
    t(8'h31, 32'hffffffff, 32'h0, 16'h12, K, 6'h20);
  endtask
  task automatic t_step;
    logic [31:0] v;
    t(8'h40, 32'h7, 32'h0, 16'h12, 32'h7, 6'h00);
    t(8'h41, 32'h7fffffff, 32'h0, 16'h12, 32'h80000000, 6'h00);
    t(8'h51, 32'h80000000, 32'h0, 16'h12, 32'h7fffffff, 6'h00);
    wm(10'h300, 32'hffffffff);
    run(8'h43, 16'h0, 16'hc8);
    rm(10'h300, v);
    chk("counter", 32'h0, v);
    run(8'h43, 16'h0, 16'hc7);
    sts(6'h20, 6'h20);
  endtask
  task automatic t_sign;
    t(8'h61, 32'hfffe7960, 32'h0, 16'h12, 32'h186a0, 6'h00);
    t(8'h61, 32'h80000000, 32'h0, 16'h12, K, 6'h20);
    t(8'h71, 32'h186a0, 32'h0, 16'h12, 32'hfffe7960, 6'h00);
    t(8'h71, 32'h80000000, 32'h0, 16'h12, K, 6'h20);
  endtask
  task automatic t_sum;
    t(8'h81, 32'hfc1803e8, 32'h7fff8000, 16'h4, 32'hffffffff, 6'h00);
    t(8'h81, 32'h1, 32'h1, 16'h0, 32'h0, 6'h02);
    t(8'h81, 32'h1, 32'h1, 16'h100, K, 6'h20);
    t(8'h91, 32'h000f4240, 32'h0007a120, 16'h2, 32'h0016e360, 6'h00);
    t(8'h91, 32'h1, 32'h1, 16'h100, K, 6'h20);
  endtask
  task automatic t_float;
    t(8'ha1, 32'h3fc00000, 32'h40100000, 16'h12, 32'h40700000, 6'h00);
    t(8'hb1, 32'h40100000, 32'h3fc00000, 16'h12, 32'h3f400000, 6'h00);
    t(8'hb1, 32'h3fc00000, 32'h3fc00000, 16'h12, 32'h0, 6'h02);
    t(8'ha1, 32'h7f000000, 32'h7f000000, 16'h12, 32'h7f800000, 6'h04);
  endtask
  initial forever #25 sys_clk = ~sys_clk;
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_int;
    t_div;
    t_sqrt;
    t_step;
    t_sign;
    t_sum;
    t_float;
    tally_and_finish;
  end
endmodule // tb
